// ---- rtl/amp_misc_control_status_regs.sv ----
// APB register bank for amplifier misc control, flag pin and status
//
// Functional notes
// - Dither field selects stages, resets to 11.
// - Direction bit: 0 input, 1 output.
// - Code 00011 flags both channels muted.
// - Codes 00100/00101 flag left/right mute.
// - Code 00110 flags clock invalid.
// - Code 01011 outputs fault, active low; 00000 drives low.
// - Bit 3 gives separate right coefficients.
// - Bit 2 bypasses the 128-tap FIR.
// - Bit 1 bypasses left/right DRC.
// - Bit 0 bypasses left/right equalizer.
// - Status bit 1 shows right muted.
// - Status bit 0 shows left muted.
// - Mute only after configured zero run.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module amp_misc_control_status_regs
    import amp_regs_pkg::*;
#(
    parameter logic [7:0] DIE_IDENTIFIER_VALUE = 8'h5a // Arbitrary value
) (
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic irq, // Level interrupt
    input wire logic left_muted, // Left channel auto muted (after zero run)
    input wire logic right_muted, // Right channel auto muted (after zero run)
    input wire logic clk_invalid_async, // Clock error or missing, from pin domain
    input wire logic fault_flag_n_async, // Device fault, active low, async
    input wire logic [7:0] power_state_code, // Power state from sequencer
    input wire logic flag_pin_in, // Multipurpose pin input level
    output logic flag_pin_out, // Multipurpose pin output level
    output logic flag_pin_oe, // Multipurpose pin drive enable
    output logic first_coefficient_marker, // Next coefficient starts a biquad
    output logic [7:0] modulator_ctrl, // Modulator settings
    output logic [3:0] dsp_bypass // Processing bypass controls
);

    ////////////////////////////////////////////////////////////////////////
    // State
    regs_state_t s_reg;
    regs_state_t s_next;
    dsp_ctrl_t dsp_q;
    mod_ctrl_t mod_q;

    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        wr_byte = strb[0] ? d[7:0] : old;
    endfunction : wr_byte

    logic access;
    logic [7:0] index;
    logic mapped;
    logic [7:0] events;
    logic fault_n_s;
    logic clk_bad_s;

    assign access = psel && penable && s_reg.pready;
    assign index = paddr[9:2];
    assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) && (
        index == IDX_COEF_MARKER || index == IDX_MOD_DAC || index == IDX_PIN_DIR ||
        index == IDX_PIN_FUNC || index == IDX_BYPASS || index == IDX_DIE_IDENTIFIER ||
        index == IDX_POWER || index == IDX_MUTE_STAT || index == IDX_IRQ_STAT ||
        index == IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next = s_reg;
        // Three-stage synchronisers; change accepted when stages 2 and 3 agree
        s_next.fault_sync = {s_reg.fault_sync[1:0], fault_flag_n_async};
        s_next.clk_sync = {s_reg.clk_sync[1:0], clk_invalid_async};
        s_next.pin_sync = {s_reg.pin_sync[1:0], flag_pin_in};
        fault_n_s = s_reg.fault_n_q;
        clk_bad_s = s_reg.clk_bad_q;
        if (s_reg.fault_sync[2] == s_reg.fault_sync[1]) begin
            fault_n_s = s_reg.fault_sync[2];
        end
        if (s_reg.clk_sync[2] == s_reg.clk_sync[1]) begin
            clk_bad_s = s_reg.clk_sync[2];
        end
        s_next.fault_n_q = fault_n_s;
        s_next.clk_bad_q = clk_bad_s;
        // Mute flags already qualified by the zero-run timer upstream
        s_next.mute_q = {right_muted, left_muted};
        s_next.power_q = power_state_code;

        // Rising edges of mute, clock and fault events; any change of power state
        events = 8'h00;
        events[EV_LEFT_MUTE] = left_muted && !s_reg.mute_q[0];
        events[EV_RIGHT_MUTE] = right_muted && !s_reg.mute_q[1];
        events[EV_CLK_INVALID] = clk_bad_s && !s_reg.clk_bad_q;
        events[EV_FAULT] = !fault_n_s && s_reg.fault_n_q;
        events[EV_POWER] = power_state_code != s_reg.power_q;

        // APB: decode at setup so ready, data and error stand in the access cycle
        s_next.pready = psel && !penable;
        s_next.pslverr = 1'b0;
        if (psel && !penable) begin
            s_next.pslverr = !mapped;
            s_next.prdata = 32'h0000_0000;
            if (!pwrite && mapped) begin
                case (index)
                    IDX_COEF_MARKER: s_next.prdata[7:0] = s_reg.coef_marker;
                    IDX_MOD_DAC: s_next.prdata[7:0] = s_reg.mod_dac;
                    IDX_PIN_DIR: s_next.prdata[7:0] = s_reg.pin_dir;
                    IDX_PIN_FUNC: s_next.prdata[7:0] = s_reg.pin_func;
                    IDX_BYPASS: s_next.prdata[7:0] = s_reg.bypass;
                    IDX_DIE_IDENTIFIER: s_next.prdata[7:0] = DIE_IDENTIFIER_VALUE;
                    IDX_POWER: s_next.prdata[7:0] = s_reg.power_q;
                    IDX_MUTE_STAT: s_next.prdata[7:0] = {6'h00, s_reg.mute_q};
                    IDX_IRQ_STAT: s_next.prdata[7:0] = s_reg.irq_stat;
                    IDX_IRQ_MASK: s_next.prdata[7:0] = s_reg.irq_mask;
                    default: s_next.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Write lands at the edge that ends the access
        if (access) begin
            s_next.pready = 1'b0;
            if (pwrite && mapped) begin
                case (index)
                    IDX_COEF_MARKER: s_next.coef_marker = wr_byte(s_reg.coef_marker, pwdata,
                                                                   pstrb);
                    IDX_MOD_DAC: s_next.mod_dac = wr_byte(s_reg.mod_dac, pwdata, pstrb);
                    IDX_PIN_DIR: s_next.pin_dir = wr_byte(s_reg.pin_dir, pwdata, pstrb);
                    IDX_PIN_FUNC: s_next.pin_func = wr_byte(s_reg.pin_func, pwdata, pstrb);
                    IDX_BYPASS: s_next.bypass = wr_byte(s_reg.bypass, pwdata, pstrb);
                    IDX_IRQ_MASK: s_next.irq_mask = wr_byte(s_reg.irq_mask, pwdata, pstrb);
                    IDX_IRQ_STAT: begin
                        if (pstrb[0]) begin
                            s_next.irq_stat = s_reg.irq_stat & ~pwdata[7:0];
                        end
                    end
                    default: ; // Read-only registers ignore writes
                endcase
            end
        end
        // Set wins over a same-cycle clear
        s_next.irq_stat = s_next.irq_stat | events;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

        // Flag pin
        s_next.pin_oe = s_next.pin_dir[0];
        case (s_next.pin_func[FUNC_W-1:0])
            FUNC_OFF: s_next.pin_out = 1'b0;
            FUNC_BOTH_MUTED: s_next.pin_out = s_next.mute_q[0] && s_next.mute_q[1];
            FUNC_LEFT_MUTED: s_next.pin_out = s_next.mute_q[0];
            FUNC_RIGHT_MUTED: s_next.pin_out = s_next.mute_q[1];
            FUNC_CLK_INVALID: s_next.pin_out = clk_bad_s;
            FUNC_FAULT: s_next.pin_out = fault_n_s;
            default: s_next.pin_out = 1'b0;
        endcase
        if (!s_next.pin_dir[0]) begin
            s_next.pin_out = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.coef_marker <= RST_COEF_MARKER;
            s_reg.mod_dac <= RST_MOD_DAC;
            s_reg.pin_dir <= RST_PIN_DIR;
            s_reg.pin_func <= RST_PIN_FUNC;
            s_reg.bypass <= RST_BYPASS;
            s_reg.irq_mask <= RST_IRQ_MASK;
            s_reg.fault_sync <= 3'b111;
            s_reg.fault_n_q <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        dsp_q.separate_coef = s_reg.bypass[BYP_SEPARATE_COEF];
        dsp_q.bypass_fir = s_reg.bypass[BYP_FIR];
        dsp_q.bypass_drc = s_reg.bypass[BYP_DRC];
        dsp_q.bypass_eq = s_reg.bypass[BYP_EQ];
        mod_q = s_reg.mod_dac;
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;
    assign flag_pin_out = s_reg.pin_out;
    assign flag_pin_oe = s_reg.pin_oe;
    assign first_coefficient_marker = s_reg.coef_marker[0];
    assign modulator_ctrl = mod_q;
    // Bit order follows the register: 3 separate coef, 2 FIR, 1 DRC, 0 EQ
    assign dsp_bypass = {dsp_q.separate_coef, dsp_q.bypass_fir, dsp_q.bypass_drc,
                         dsp_q.bypass_eq};

endmodule : amp_misc_control_status_regs

// ---- rtl/amp_regs_pkg.sv ----
// Constants and types for the amplifier misc control and status register bank
package amp_regs_pkg;

    // Printed offsets are not multiples of four: these are register indices
    localparam logic [7:0] IDX_COEF_MARKER = 8'h5c;
    localparam logic [7:0] IDX_MOD_DAC = 8'h5d;
    localparam logic [7:0] IDX_PIN_DIR = 8'h60;
    localparam logic [7:0] IDX_PIN_FUNC = 8'h61;
    localparam logic [7:0] IDX_BYPASS = 8'h66;
    localparam logic [7:0] IDX_DIE_IDENTIFIER = 8'h67;
    localparam logic [7:0] IDX_POWER = 8'h68;
    localparam logic [7:0] IDX_MUTE_STAT = 8'h69;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

    localparam logic [7:0] RST_COEF_MARKER = 8'h00;
    localparam logic [7:0] RST_MOD_DAC = 8'hf8;
    localparam logic [7:0] RST_PIN_DIR = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC = 8'h00;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // Field positions
    localparam int DITHER_LSB = 5;
    localparam int BYP_SEPARATE_COEF = 3;
    localparam int BYP_FIR = 2;
    localparam int BYP_DRC = 1;
    localparam int BYP_EQ = 0;
    localparam int FUNC_W = 5;

    // Pin function codes
    localparam logic [4:0] FUNC_OFF = 5'h00;
    localparam logic [4:0] FUNC_BOTH_MUTED = 5'h03;
    localparam logic [4:0] FUNC_LEFT_MUTED = 5'h04;
    localparam logic [4:0] FUNC_RIGHT_MUTED = 5'h05;
    localparam logic [4:0] FUNC_CLK_INVALID = 5'h06;
    localparam logic [4:0] FUNC_FAULT = 5'h0b;

    // Interrupt status bits
    localparam int EV_LEFT_MUTE = 0;
    localparam int EV_RIGHT_MUTE = 1;
    localparam int EV_CLK_INVALID = 2;
    localparam int EV_FAULT = 3;
    localparam int EV_POWER = 4;

    // Zero-run length at 96 kHz for the shortest auto-mute time
    localparam int MUTE_TIME_US = 11500;
    localparam int MUTE_SAMPLES_96K = MUTE_TIME_US * 96 / 1000;

    typedef struct packed {
        logic [7:0] coef_marker;
        logic [7:0] mod_dac;
        logic [7:0] pin_dir;
        logic [7:0] pin_func;
        logic [7:0] bypass;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic pin_out;
        logic pin_oe;
        logic [2:0] fault_sync;
        logic [2:0] clk_sync;
        logic [2:0] pin_sync;
        logic fault_n_q;
        logic clk_bad_q;
        logic [1:0] mute_q;
        logic [7:0] power_q;
    } regs_state_t;

    typedef struct packed {
        logic bypass_eq;
        logic bypass_drc;
        logic bypass_fir;
        logic separate_coef;
    } dsp_ctrl_t;

    typedef struct packed {
        logic freq_sel;
        logic [1:0] dither_en;
        logic [2:0] dither_level;
        logic [1:0] element_matching_select;
    } mod_ctrl_t;

endpackage : amp_regs_pkg

// ---- tb/amp_regs_chk.sv ----
// Port checker for the amplifier misc control and status register bank
`timescale 1ns/10ps
module amp_regs_chk
    import amp_regs_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // APB
    input wire logic penable, // APB
    input wire logic pwrite, // APB
    input wire logic [11:0] paddr, // APB
    input wire logic [31:0] pwdata, // APB
    input wire logic [3:0] pstrb, // APB
    input wire logic [31:0] prdata, // APB
    input wire logic pready, // APB
    input wire logic pslverr, // APB
    input wire logic irq, // Interrupt
    input wire logic left_muted, // Mute in
    input wire logic right_muted, // Mute in
    input wire logic flag_pin_out, // Pin
    input wire logic flag_pin_oe, // Pin
    input wire logic [3:0] dsp_bypass // Bypass
);
    logic [7:0] dir_q, func_q, byp_q, mask_q, idx;
    logic mapped, wr_ok, exp_mute;
    assign idx = paddr[9:2];
    assign mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 && idx inside {IDX_COEF_MARKER,
        IDX_MOD_DAC, IDX_PIN_DIR, IDX_PIN_FUNC, IDX_BYPASS, IDX_DIE_IDENTIFIER, IDX_POWER,
        IDX_MUTE_STAT, IDX_IRQ_STAT, IDX_IRQ_MASK};
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign exp_mute = func_q[4:0] == FUNC_BOTH_MUTED ? left_muted && right_muted :
        func_q[4:0] == FUNC_LEFT_MUTED ? left_muted : right_muted;
    // Shadow of the registers that steer the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= RST_PIN_DIR;
            func_q <= RST_PIN_FUNC;
            byp_q <= RST_BYPASS;
            mask_q <= RST_IRQ_MASK;
        end else if (wr_ok) begin
            case (idx)
                IDX_PIN_DIR: dir_q <= pwdata[7:0];
                IDX_PIN_FUNC: func_q <= pwdata[7:0];
                IDX_BYPASS: byp_q <= pwdata[7:0];
                IDX_IRQ_MASK: mask_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    AST_PREADY_SETUP: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_PRDATA_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_SLVERR: assert property (s_setup |=> pslverr == !$past(mapped))
        else $error("error response wrong");
    AST_OE_DIR: assert property (($stable(dir_q))[*3] |-> flag_pin_oe == dir_q[0])
        else $error("pin enable differs from direction");
    AST_PIN_INPUT_LOW: assert property ((!dir_q[0])[*3] |-> !flag_pin_out)
        else $error("pin driven high while input");
    AST_PIN_MUTE: assert property ((dir_q[0] && func_q[4:0] inside {5'h03, 5'h04, 5'h05} &&
        $stable(func_q) && $stable({left_muted, right_muted}))[*3] |-> flag_pin_out == exp_mute)
        else $error("mute flag on pin wrong");
    AST_PIN_OFF: assert property ((dir_q[0] && func_q[4:0] == FUNC_OFF)[*3] |-> !flag_pin_out)
        else $error("pin not low when off");
    AST_BYPASS: assert property (($stable(byp_q))[*3] |-> dsp_bypass == byp_q[3:0])
        else $error("bypass outputs differ from register");
    AST_IRQ_MASKED: assert property ((mask_q == 8'h00)[*3] |-> !irq)
        else $error("interrupt while all masked");
endmodule : amp_regs_chk

bind amp_misc_control_status_regs amp_regs_chk u_amp_regs_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq, .left_muted, .right_muted,
    .flag_pin_out, .flag_pin_oe, .dsp_bypass);

// ---- tb/amp_misc_control_status_regs_tb_top.sv ----
// Testbench for the amplifier misc control and status register bank
`timescale 1ns/10ps
module amp_misc_control_status_regs_tb_top;
    import amp_regs_pkg::*;
    localparam logic [7:0] DIE_IDENTIFIER_TB = 8'h3c; // Arbitrary value
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, left_muted = 0;
    logic right_muted = 0, clk_invalid_async = 0, fault_flag_n_async = 1, flag_pin_in = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf, dsp_bypass;
    logic [7:0] power_state_code = '0, modulator_ctrl;
    logic pready, pslverr, irq, flag_pin_out, flag_pin_oe, first_coefficient_marker, er;
    int n_errors = 0, compares = 0;
    always #4 pclk = ~pclk;
    amp_misc_control_status_regs #(.DIE_IDENTIFIER_VALUE(DIE_IDENTIFIER_TB)) u_amp_misc_control_status_regs (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .irq, .left_muted, .right_muted, .clk_invalid_async, .fault_flag_n_async,
        .power_state_code, .flag_pin_in, .flag_pin_out, .flag_pin_oe, .first_coefficient_marker,
        .modulator_ctrl, .dsp_bypass);
    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            n_errors++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
        repeat (6) @(posedge pclk);
    endtask : wr
    task rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, {24'h0, exp});
    endtask : rdc
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk(modulator_ctrl, RST_MOD_DAC);
        chk({flag_pin_oe, flag_pin_out, dsp_bypass}, 0);
        rdc(IDX_COEF_MARKER, RST_COEF_MARKER);
        rdc(IDX_MOD_DAC, RST_MOD_DAC);
        rdc(IDX_PIN_DIR, RST_PIN_DIR);
        rdc(IDX_PIN_FUNC, RST_PIN_FUNC);
        rdc(IDX_BYPASS, RST_BYPASS);
        rdc(IDX_DIE_IDENTIFIER, DIE_IDENTIFIER_TB);
    endtask : t_reset
    task t_ctrl;
        wr(IDX_COEF_MARKER, 8'h81);
        chk(first_coefficient_marker, 1);
        rdc(IDX_COEF_MARKER, 8'h81);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_MOD_DAC, {1'b1, i[1:0], 5'h18});
            chk(modulator_ctrl[6:5], i[1:0]);
            wr(IDX_BYPASS, 8'h01 << i);
            chk(dsp_bypass, 4'h1 << i);
        end
    endtask : t_ctrl
    task t_ro;
        for (int i = 0; i < 4; i++) begin
            power_state_code <= i[7:0];
            {right_muted, left_muted} <= i[1:0];
            repeat (4) @(posedge pclk);
            rdc(IDX_POWER, i[7:0]);
            rdc(IDX_MUTE_STAT, i[7:0]);
        end
        wr(IDX_DIE_IDENTIFIER, 8'hff);
        wr(IDX_POWER, 8'hff);
        wr(IDX_MUTE_STAT, 8'hff);
        rdc(IDX_DIE_IDENTIFIER, DIE_IDENTIFIER_TB);
        rdc(IDX_POWER, 8'h03);
        rdc(IDX_MUTE_STAT, 8'h03);
        apb(1'b0, 8'h3c, 32'h0);
        chk(er, 1);
    endtask : t_ro
    task t_pin;
        wr(IDX_PIN_DIR, 8'h01);
        chk(flag_pin_oe, 1);
        for (int i = 0; i < 4; i++) begin
            {right_muted, left_muted} <= i[1:0];
            wr(IDX_PIN_FUNC, FUNC_BOTH_MUTED);
            chk(flag_pin_out, i == 3);
            wr(IDX_PIN_FUNC, FUNC_LEFT_MUTED);
            chk(flag_pin_out, i[0]);
            wr(IDX_PIN_FUNC, FUNC_RIGHT_MUTED);
            chk(flag_pin_out, i[1]);
        end
        clk_invalid_async <= 1'b1;
        wr(IDX_PIN_FUNC, FUNC_CLK_INVALID);
        chk(flag_pin_out, 1);
        clk_invalid_async <= 1'b0;
        fault_flag_n_async <= 1'b0;
        wr(IDX_PIN_FUNC, FUNC_FAULT);
        chk(flag_pin_out, 0);
        fault_flag_n_async <= 1'b1;
        wr(IDX_PIN_FUNC, FUNC_FAULT);
        chk(flag_pin_out, 1);
        wr(IDX_PIN_FUNC, FUNC_OFF);
        chk(flag_pin_out, 0);
        wr(IDX_PIN_DIR, 8'h00);
        chk({flag_pin_oe, flag_pin_out}, 0);
    endtask : t_pin
    task t_irq;
        {right_muted, left_muted} <= 2'b00;
        wr(IDX_IRQ_STAT, 8'h1f);
        left_muted <= 1'b1;
        wr(IDX_IRQ_MASK, 8'h00);
        chk(irq, 0);
        rdc(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_MASK, 8'h01);
        chk(irq, 1);
        wr(IDX_IRQ_STAT, 8'h01);
        chk(irq, 0);
    endtask : t_irq
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ctrl();
        t_ro();
        t_pin();
        t_irq();
        wrap_up();
    end
endmodule : amp_misc_control_status_regs_tb_top
